// ===== qcwd_pkg.sv
// Package with constants for the quadrature clock watchdog.
package qcwd_pkg;
	localparam int          CNT_W        = 16;
	localparam int          DIV_RATIO    = 64;
	localparam int          DIV_W        = 6;
	localparam logic [5:0]  DIV_LAST     = 6'h3F;
	localparam logic [5:0]  DIV_RST      = 6'h00;
	localparam logic [15:0] CNT_RST      = 16'h0000;
	localparam logic [15:0] CNT_ONE      = 16'h0001;
	localparam logic [15:0] PERIOD_RST   = 16'h0000;
endpackage

// ===== qcwd_tick_div.sv
// Divider that turns the system clock into a one-in-64 tick pulse.
`timescale 1ns/1ps
module qcwd_tick_div #(
	parameter int RATIO = qcwd_pkg::DIV_RATIO
) (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	output logic      tick
);
	logic [qcwd_pkg::DIV_W-1:0] div_ff;

	// The tick is a single-cycle enable so the counter stays on one clock.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_ff <= qcwd_pkg::DIV_RST;
		end else if (div_ff == qcwd_pkg::DIV_W'(RATIO - 1)) begin
			div_ff <= qcwd_pkg::DIV_RST;
		end else begin
			div_ff <= div_ff + qcwd_pkg::DIV_W'(1);
		end
	end

	assign tick = (div_ff == qcwd_pkg::DIV_W'(RATIO - 1));
endmodule

// ===== qcwd_watchdog.sv
// Quadrature clock watchdog with programmable period and sticky timeout flag.
// Functional notes
// - A 16-bit counter supervises the quadrature clock to confirm motion continues.
// - The counter advances only on a tick of the system clock divided by 64.
// - Each quadrature clock pulse clears the counter to zero.
// - Counter reaching the period without a pulse sets the timeout flag.
// - Software programs the period; the counter is compared with the stored value.
`timescale 1ns/1ps
module qcwd_watchdog #(
	parameter int CNT_W = qcwd_pkg::CNT_W
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic             qclk_pulse,
	input  wire logic             wd_enable,
	input  wire logic             period_wr,
	input  wire logic [CNT_W-1:0] period_wdata,
	input  wire logic             flag_clr,
	input  wire logic             irq_enable,
	output logic      [CNT_W-1:0] count_out,
	output logic      [CNT_W-1:0] period_out,
	output logic                  timeout_flag,
	output logic                  irq
);
	logic             tick;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] period_ff;
	logic             flag_ff;
	logic             irq_ff;
	logic             match;
	logic [qcwd_pkg::DIV_W-1:0] gap_ff;

	qcwd_tick_div #(
		.RATIO(qcwd_pkg::DIV_RATIO)
	) u_div (
		.ref_clk(ref_clk),
		.rst_n  (rst_n),
		.tick   (tick)
	);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			period_ff <= CNT_W'(qcwd_pkg::PERIOD_RST);
		end else if (period_wr) begin
			period_ff <= period_wdata;
		end
	end

	// A match needs no pulse, so a pulse in the same cycle restarts the interval instead of timing out.
	assign match = wd_enable && tick && !qclk_pulse && (cnt_ff == period_ff);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= CNT_W'(qcwd_pkg::CNT_RST);
		end else if (!wd_enable || qclk_pulse) begin
			cnt_ff <= CNT_W'(qcwd_pkg::CNT_RST);
		end else if (match) begin
			cnt_ff <= CNT_W'(qcwd_pkg::CNT_RST);
		end else if (tick) begin
			cnt_ff <= cnt_ff + CNT_W'(qcwd_pkg::CNT_ONE);
		end
	end

	// Set wins over clear so a timeout in the clearing cycle is not lost.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_ff <= 1'b0;
		end else if (match) begin
			flag_ff <= 1'b1;
		end else if (flag_clr) begin
			flag_ff <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= irq_enable && (flag_ff || match);
		end
	end

	assign count_out    = cnt_ff;
	assign period_out   = period_ff;
	assign timeout_flag = flag_ff;
	assign irq          = irq_ff;

	// Cycles since the last tick, kept apart from the divider to check its spacing.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_ff <= qcwd_pkg::DIV_RST;
		end else if (tick) begin
			gap_ff <= qcwd_pkg::DIV_RST;
		end else begin
			gap_ff <= gap_ff + qcwd_pkg::DIV_W'(1);
		end
	end

	a_pulse_clears: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		qclk_pulse
		|=> (cnt_ff == '0)
	) else $error("Counter not cleared after quadrature pulse.");

	a_no_tick_hold: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(!tick && !qclk_pulse && wd_enable)
		|=> $stable(cnt_ff)
	) else $error("Counter moved without a divider tick.");

	a_tick_step: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(tick && wd_enable && !qclk_pulse && !match)
		|=> (cnt_ff == $past(cnt_ff) + CNT_W'(qcwd_pkg::CNT_ONE))
	) else $error("Counter did not step on tick.");

	a_tick_spacing: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		tick
		|=> !tick [*8]
	) else $error("Divider ticks too close together.");

	a_timeout_sets: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		match
		|=> flag_ff
	) else $error("Timeout flag not set on period match.");

	a_flag_sticky: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(flag_ff && !flag_clr)
		|=> flag_ff
	) else $error("Timeout flag dropped without clear.");

	a_flag_cause: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(flag_ff)
		|-> $past(match)
	) else $error("Timeout flag rose without a match.");

	a_irq_gated: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		irq_ff
		|-> $past(irq_enable)
	) else $error("Interrupt raised while disabled.");

	a_irq_follows: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(flag_ff && irq_enable)
		|=> irq_ff
	) else $error("Interrupt missing for enabled flag.");

	a_tick_gap: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		tick
		== (gap_ff == qcwd_pkg::DIV_LAST)
	) else $error("Divider tick not one in every divide ratio cycles.");

	a_count_moves: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		($changed(cnt_ff) && (cnt_ff != '0))
		|-> $past(tick)
	) else $error("Counter advanced without a divider tick.");

	a_count_off: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		!wd_enable
		|=> (cnt_ff == '0)
	) else $error("Counter not held at zero while disabled.");

	a_match_restart: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		match
		|=> (cnt_ff == '0)
	) else $error("Counter not restarted after timeout.");

	a_period_match: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(wd_enable && tick && !qclk_pulse && (cnt_ff == period_ff))
		|=> (flag_ff && (cnt_ff == '0))
	) else $error("Counter equal to period on tick gave no timeout.");

	a_count_bound: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		((cnt_ff <= period_ff) && !period_wr)
		|=> (cnt_ff <= period_ff)
	) else $error("Counter ran past the stored period.");

	a_period_store: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		period_wr
		|=> (period_ff == $past(period_wdata))
	) else $error("Period write not stored.");

	a_period_hold: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		!period_wr
		|=> $stable(period_ff)
	) else $error("Stored period changed without a write.");

	a_flag_enable: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(flag_ff)
		|-> $past(wd_enable)
	) else $error("Timeout flag rose while the watchdog was off.");

	a_flag_clear: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(flag_clr && !match)
		|=> !flag_ff
	) else $error("Timeout flag not cleared by clear strobe.");

	a_irq_rise: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(match && irq_enable)
		|=> irq_ff
	) else $error("Interrupt missing after enabled timeout.");

	a_irq_quiet: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(!flag_ff && !match)
		|=> !irq_ff
	) else $error("Interrupt raised without a timeout.");
endmodule

// ===== qcwd_pulse_src.sv
// Decoder stand-in that sends one-cycle quadrature pulses.
`timescale 1ns/1ps
module qcwd_pulse_src (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic run,
	output logic      qclk_pulse
);
	logic [7:0] cnt_ff;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff     <= 8'h00;
			qclk_pulse <= 1'b0;
		end else begin
			cnt_ff     <= (run && cnt_ff != 8'h63) ? cnt_ff + 8'h01 : 8'h00;
			qclk_pulse <= run && cnt_ff == 8'h63;
		end
	end
endmodule

// ===== qcwd_tb.sv
// Self-checking bench for the watchdog.
`timescale 1ns/1ps
module testbench;
	logic        ref_clk = 1'b0, rst_n = 1'b0, run = 1'b0, wd_enable = 1'b0, period_wr = 1'b0;
	logic        flag_clr = 1'b0, irq_enable = 1'b0, qclk_pulse, timeout_flag, irq;
	logic [15:0] period_wdata = 16'h0000, count_out, period_out, c0;
	int          num_errors = 0, checked = 0;
	always #2 ref_clk = ~ref_clk;
	qcwd_pulse_src i_src (.ref_clk, .rst_n, .run, .qclk_pulse);
	qcwd_watchdog i_dut (.ref_clk, .rst_n, .qclk_pulse, .wd_enable, .period_wr, .period_wdata,
		.flag_clr, .irq_enable, .count_out, .period_out, .timeout_flag, .irq);
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic report_and_stop;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic set_period(input logic [15:0] p);
		period_wdata = p;
		period_wr = 1'b1;
		step(1);
		period_wr = 1'b0;
		chk(period_out, p);
	endtask
	task automatic t_tick;
		chk(count_out, 16'h0000);
		set_period(16'hFFFF);
		wd_enable = 1'b1;
		for (int i = 0; i < 70 && count_out === 16'h0000; i++) step(1);
		c0 = count_out;
		step(63);
		chk(count_out, c0);
		step(1);
		chk(count_out, c0 + 16'h0001);
		wd_enable = 1'b0;
		step(1);
	endtask
	task automatic t_timeout;
		set_period(16'h0003);
		wd_enable = 1'b1;
		irq_enable = 1'b1;
		run = 1'b1;
		step(1000);
		chk(16'(timeout_flag), 16'h0000);
		run = 1'b0;
		step(400);
		chk(16'(timeout_flag), 16'h0001);
		chk(16'(irq), 16'h0001);
		irq_enable = 1'b0;
		step(2);
		chk(16'(irq), 16'h0000);
		wd_enable = 1'b0;
		step(1);
		flag_clr = 1'b1;
		step(1);
		flag_clr = 1'b0;
		chk(16'(timeout_flag), 16'h0000);
	endtask
	task automatic t_set_wins;
		set_period(16'h0000);
		wd_enable = 1'b1;
		flag_clr = 1'b1;
		for (int i = 0; i < 70 && timeout_flag !== 1'b1; i++) step(1);
		chk(16'(timeout_flag), 16'h0001);
		chk(count_out, 16'h0000);
		wd_enable = 1'b0;
		step(1);
		chk(16'(timeout_flag), 16'h0000);
		flag_clr = 1'b0;
	endtask
	initial begin
		#40000;
		num_errors++;
		report_and_stop;
	end
	initial begin
		step(16);
		rst_n = 1'b1;
		t_tick;
		t_timeout;
		t_set_wins;
		report_and_stop;
	end
endmodule
